/* design/cbt_core.sv */
// Purpose: CAN bit timing, bit stream framing and register slave
// Assumes: aclk at 125 MHz is the quantum source; pins via a transceiver
// Notes:   Frames carry one data byte and a 15-bit CRC; no message RAM
//
// The AXI4-Lite interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module cbt_core (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [7:0]  awaddr,
    input  wire logic        wvalid,
    output logic             wready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    output logic             bvalid,
    input  wire logic        bready,
    output logic [1:0]       bresp,
    // AXI4-Lite read
    input  wire logic        arvalid,
    output logic             arready,
    input  wire logic [7:0]  araddr,
    output logic             rvalid,
    input  wire logic        rready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    // CAN pins
    input  wire logic        bus_receive_pin,
    output logic             bus_transmit_pin
);
    import cbt_pkg::*;

    logic [15:0]   ctrl;
    cbt_btime_t    btime;
    logic [7:0]    tx_data;
    logic [7:0]    rx_data;
    logic          bus_off, rx_flag, tx_flag, err_flag;
    logic          aw_full, w_full;
    logic [7:0]    aw_addr;
    logic [31:0]   w_data;
    logic [3:0]    w_strb;

    // Register slave: address and data are taken in either order
    assign awready = !aw_full && !bvalid;
    assign wready  = !w_full && !bvalid;
    assign arready = !rvalid;
    wire do_write  = aw_full && w_full && !bvalid;
    wire lane0     = w_strb[0];
    wire lane1     = w_strb[1];
    wire wr_ctrl   = do_write && aw_addr == CTRL_OFS;
    wire wr_stat   = do_write && aw_addr == STAT_OFS;
    wire wr_btime  = do_write && aw_addr == BTIME_OFS;
    wire wr_txd    = do_write && aw_addr == TXD_OFS;
    wire wr_hit    = wr_ctrl || wr_stat || wr_btime || wr_txd;
    wire rd_hit    = araddr == CTRL_OFS || araddr == STAT_OFS || araddr == BTIME_OFS ||
                     araddr == TXD_OFS || araddr == RXD_OFS;

    cbt_seg_t seg;
    assign seg.seg1_nom = {1'b0, btime.before_sample_field} + 5'h01;
    assign seg.seg2_nom = {2'b00, btime.after_sample_field} + 5'h01;
    assign seg.jump     = {1'b0, btime.resync_jump_limit} + 3'h1;
    wire [4:0] bit_len  = {1'b0, btime.before_sample_field} +
                          {2'b00, btime.after_sample_field} + SEG_ADD;
    wire [15:0] status  = {5'h00, err_flag, tx_flag, rx_flag, bus_off, 2'b00, bit_len};
    wire [15:0] rd_mux  = araddr == CTRL_OFS  ? ctrl :
                          araddr == STAT_OFS  ? status :
                          araddr == BTIME_OFS ? btime :
                          araddr == TXD_OFS   ? {8'h00, tx_data} :
                          araddr == RXD_OFS   ? {8'h00, rx_data} : 16'h0000;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full <= 1'b0;
            w_full  <= 1'b0;
            bvalid  <= 1'b0;
            bresp   <= RESP_OKAY;
            rvalid  <= 1'b0;
            rresp   <= RESP_OKAY;
            rdata   <= 32'h00000000;
            aw_addr <= 8'h00;
            w_data  <= 32'h00000000;
            w_strb  <= 4'h0;
        end else begin
            if (awvalid && awready) begin
                aw_full <= 1'b1;
                aw_addr <= {awaddr[7:2], 2'b00};
            end
            if (wvalid && wready) begin
                w_full <= 1'b1;
                w_data <= wdata;
                w_strb <= wstrb;
            end
            if (do_write) begin
                aw_full <= 1'b0;
                w_full  <= 1'b0;
                bvalid  <= 1'b1;
                bresp   <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
            if (arvalid && arready) begin
                rvalid <= 1'b1;
                rdata  <= {16'h0000, rd_mux};
                rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (rvalid && rready) begin
                rvalid <= 1'b0;
            end
        end
    end

    // Pin sampling: a level counts once the second and third stages agree
    logic rx_s1, rx_s2, rx_s3, rx_lvl;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {rx_s1, rx_s2, rx_s3, rx_lvl} <= 4'hF;
        end else begin
            {rx_s1, rx_s2, rx_s3} <= {bus_receive_pin, rx_s1, rx_s2};
            if (rx_s2 == rx_s3) begin
                rx_lvl <= rx_s3;
            end
        end
    end

    // Quantum prescaler
    wire       run = !ctrl[HOLD_POS];
    logic [5:0] pre_cnt;
    wire       tq_tick = run && pre_cnt == btime.quantum_prescaler;
    always_ff @(posedge aclk) begin
        if (!aresetn || !run) begin
            pre_cnt <= 6'h00;
        end else begin
            pre_cnt <= tq_tick ? 6'h00 : pre_cnt + 6'h01;
        end
    end

    // Bit timing machine
    cbt_bt_state_t bt_state, next_bt_state;
    cbt_bs_state_t bs_state;
    logic [4:0] qcnt, seg1_lim, seg2_lim, next_qcnt, next_seg1_lim, next_seg2_lim;
    logic       synced, prev_smp, smp_tick, bit_start;
    wire        hard_sync_en = bs_state == BS_IDLE;
    wire        edge_seen = tq_tick && prev_smp && !rx_lvl && !synced;
    wire [4:0]  pos_err   = qcnt + 5'h01;
    wire [4:0]  neg_err   = seg2_lim - qcnt;
    wire [4:0]  jump5     = {2'b00, seg.jump};
    wire [4:0]  pos_adj   = pos_err < jump5 ? pos_err : jump5;
    wire [4:0]  seg1_eff  = (edge_seen && bt_state == BT_SEG1) ? seg1_lim + pos_adj : seg1_lim;
    wire        early_end = edge_seen && bt_state == BT_SEG2 && neg_err <= jump5;

    always_comb begin
        next_bt_state = bt_state;
        next_qcnt     = qcnt;
        next_seg1_lim = seg1_lim;
        next_seg2_lim = seg2_lim;
        smp_tick      = 1'b0;
        bit_start     = 1'b0;
        if (tq_tick) begin
            if (edge_seen && hard_sync_en) begin
                next_bt_state = BT_SEG1;
                next_qcnt     = 5'h00;
                next_seg1_lim = seg.seg1_nom;
                next_seg2_lim = seg.seg2_nom;
            end else begin
                case (bt_state)
                    BT_SYNC: begin
                        next_bt_state = BT_SEG1;
                        next_qcnt     = 5'h00;
                        next_seg1_lim = seg.seg1_nom;
                        next_seg2_lim = seg.seg2_nom;
                        bit_start     = 1'b1;
                    end
                    BT_SEG1: begin
                        next_seg1_lim = seg1_eff;
                        if (qcnt + 5'h01 == seg1_eff) begin
                            next_bt_state = BT_SEG2;
                            next_qcnt     = 5'h00;
                            smp_tick      = 1'b1;
                        end else begin
                            next_qcnt = qcnt + 5'h01;
                        end
                    end
                    BT_SEG2: begin
                        if (early_end) begin
                            // This quantum becomes the sync slot; limits reload nominal
                            next_bt_state = BT_SEG1;
                            next_qcnt     = 5'h00;
                            next_seg1_lim = seg.seg1_nom;
                            next_seg2_lim = seg.seg2_nom;
                            bit_start     = 1'b1;
                        end else if (qcnt + 5'h01 ==
                                     (edge_seen ? seg2_lim - jump5 : seg2_lim)) begin
                            next_bt_state = BT_SYNC;
                            next_qcnt     = 5'h00;
                        end else begin
                            next_seg2_lim = edge_seen ? seg2_lim - jump5 : seg2_lim;
                            next_qcnt     = qcnt + 5'h01;
                        end
                    end
                    default: next_bt_state = BT_SYNC;
                endcase
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || !run) begin
            bt_state <= BT_SYNC;
            qcnt     <= 5'h00;
            seg1_lim <= 5'h01;
            seg2_lim <= 5'h01;
            synced   <= 1'b0;
            prev_smp <= 1'b1;
        end else begin
            bt_state <= next_bt_state;
            qcnt     <= next_qcnt;
            seg1_lim <= next_seg1_lim;
            seg2_lim <= next_seg2_lim;
            if (smp_tick) begin
                synced   <= 1'b0;
                prev_smp <= rx_lvl;
            end else if (edge_seen) begin
                synced <= 1'b1;
            end
        end
    end

    // Bit stream machine
    logic [4:0]  bcnt;
    logic [2:0]  same_cnt;
    logic        last_bit, transmitting, tx_bit_next;
    logic [7:0]  shreg;
    logic [14:0] crc;
    logic [8:0]  err_cnt;
    wire         bit_in   = rx_lvl;
    wire         stuff_now = same_cnt == STUFF_LEN;
    wire         fb        = bit_in ^ crc[14];
    wire [14:0]  crc_next  = {crc[13:0], 1'b0} ^ (fb ? CRC_POLY : 15'h0000);
    wire [7:0]   sh_next   = {shreg[6:0], bit_in};
    wire [2:0]   same_next = bit_in == last_bit ? same_cnt + 3'h1 : 3'h1;
    wire         in_data   = bcnt <= DATA_LAST;
    wire         lost_arb  = transmitting && bus_transmit_pin && !bit_in && in_data;
    wire         stuff_err = stuff_now && bit_in == last_bit;
    wire         bit_err   = transmitting && bus_transmit_pin != bit_in && !lost_arb;
    wire         crc_err   = !stuff_now && bcnt == CRC_LAST && crc_next != 15'h0000;
    wire         frame_err = stuff_err || bit_err || crc_err;
    wire [8:0]   err_sum   = err_cnt + ERR_STEP;
    wire         go_off    = transmitting && err_sum[8];
    wire         tx_bit_data = stuff_now || same_next == STUFF_LEN ? !bit_in :
                               bcnt < DATA_LAST ? sh_next[7] : crc_next[14];
    // After a stuff bit the deferred data or CRC bit goes out, not another inverse
    wire         tx_bit_resume = bcnt <= DATA_LAST ? shreg[7] : crc[14];

    always_ff @(posedge aclk) begin
        if (!aresetn || !run) begin
            bs_state     <= BS_WAIT;
            bcnt         <= 5'h00;
            same_cnt     <= 3'h0;
            last_bit     <= 1'b1;
            transmitting <= 1'b0;
            tx_bit_next  <= 1'b1;
            crc          <= 15'h0000;
            shreg        <= 8'h00;
            err_cnt      <= 9'h000;
        end else if (smp_tick) begin
            case (bs_state)
                BS_WAIT: begin
                    bcnt     <= bit_in ? bcnt + 5'h01 : 5'h00;
                    bs_state <= (bit_in && bcnt + 5'h01 >= IDLE_BITS) ? BS_IDLE : BS_WAIT;
                end
                BS_IDLE: begin
                    tx_bit_next <= !ctrl[TXREQ_POS];
                    if (!bit_in) begin
                        bs_state     <= BS_FRAME;
                        bcnt         <= 5'h01;
                        same_cnt     <= 3'h1;
                        last_bit     <= 1'b0;
                        crc          <= 15'h0000;
                        transmitting <= !bus_transmit_pin;
                        shreg        <= tx_data;
                        tx_bit_next  <= bus_transmit_pin | tx_data[7];
                    end
                end
                BS_FRAME: begin
                    if (frame_err) begin
                        bs_state    <= BS_FLAG;
                        bcnt        <= 5'h00;
                        tx_bit_next <= 1'b0;
                        err_cnt     <= transmitting ? err_sum : err_cnt;
                    end else if (stuff_now) begin
                        same_cnt    <= 3'h1;
                        last_bit    <= bit_in;
                        tx_bit_next <= transmitting ? tx_bit_resume : 1'b1;
                    end else begin
                        same_cnt    <= same_next;
                        last_bit    <= bit_in;
                        crc         <= crc_next;
                        shreg       <= in_data ? sh_next : shreg;
                        bcnt        <= bcnt + 5'h01;
                        transmitting <= transmitting && !lost_arb;
                        tx_bit_next <= (transmitting && !lost_arb) ? tx_bit_data : 1'b1;
                        if (bcnt == CRC_LAST) begin
                            bs_state    <= BS_WAIT;
                            bcnt        <= 5'h00;
                            tx_bit_next <= 1'b1;
                            err_cnt     <= (transmitting && err_cnt != 9'h000) ?
                                           err_cnt - 9'h001 : err_cnt;
                        end
                    end
                end
                BS_FLAG: begin
                    tx_bit_next <= bcnt + 5'h01 >= FLAG_BITS;
                    bs_state    <= bcnt + 5'h01 >= FLAG_BITS ? BS_WAIT : BS_FLAG;
                    bcnt        <= bcnt + 5'h01 >= FLAG_BITS ? 5'h00 : bcnt + 5'h01;
                end
                default: bs_state <= BS_WAIT;
            endcase
        end
    end

    wire frame_done = smp_tick && bs_state == BS_FRAME && !frame_err && !stuff_now &&
                      bcnt == CRC_LAST;
    wire err_evt    = smp_tick && bs_state == BS_FRAME && frame_err;
    wire take_tx    = smp_tick && bs_state == BS_IDLE && !bit_in && !bus_transmit_pin;

    // Control, timing and status registers; hardware sets win over clears
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl     <= CTRL_RST;
            btime    <= BTIME_RST;
            bus_off  <= 1'b0;
            rx_flag  <= 1'b0;
            tx_flag  <= 1'b0;
            err_flag <= 1'b0;
        end else begin
            if (wr_ctrl && lane0) begin
                ctrl <= {14'h0000, w_data[TXREQ_POS], w_data[HOLD_POS]};
                bus_off <= bus_off && w_data[HOLD_POS];
            end
            if (take_tx) begin
                ctrl[TXREQ_POS] <= 1'b0;
            end
            if (err_evt && go_off) begin
                ctrl[HOLD_POS] <= 1'b1;
                bus_off        <= 1'b1;
            end
            // Timing fields change only while the core is held
            if (wr_btime && ctrl[HOLD_POS]) begin
                if (lane0) btime[7:0]  <= w_data[7:0];
                if (lane1) btime[15:8] <= {1'b0, w_data[14:8]};
            end
            rx_flag  <= (frame_done && !transmitting) ||
                        (rx_flag && !(wr_stat && lane1 && w_data[RXF_POS]));
            tx_flag  <= (frame_done && transmitting) ||
                        (tx_flag && !(wr_stat && lane1 && w_data[TXF_POS]));
            err_flag <= err_evt || (err_flag && !(wr_stat && lane1 && w_data[ERRF_POS]));
        end
    end

    // Message bytes have no reset so a reset keeps their contents
    always_ff @(posedge aclk) begin
        if (wr_txd && lane0) begin
            tx_data <= w_data[7:0];
        end
        if (frame_done && !transmitting) begin
            rx_data <= shreg;
        end
    end

    // Transmit pin changes only at a bit start or hard sync; hold forces it recessive
    always_ff @(posedge aclk) begin
        if (!aresetn || !run) begin
            bus_transmit_pin <= 1'b1;
        end else if (bit_start || (tq_tick && edge_seen && hard_sync_en)) begin
            bus_transmit_pin <= tx_bit_next;
        end
    end

    a_hold_recessive: assert property (@(posedge aclk) disable iff (!aresetn)
        ctrl[HOLD_POS] |=> bus_transmit_pin) else $error("pin driven while held");
    a_reset_ctrl: assert property (@(posedge aclk)
        !aresetn |=> ctrl == CTRL_RST && !bus_off) else $error("bad reset state");
    a_quantum_gap: assert property (@(posedge aclk) disable iff (!aresetn)
        tq_tick && btime.quantum_prescaler != 6'h00 |=> !tq_tick) else $error("quantum short");
    a_sample_space: assert property (@(posedge aclk) disable iff (!aresetn)
        smp_tick |=> !smp_tick ##1 !smp_tick) else $error("sample points too close");
    a_stream_gate: assert property (@(posedge aclk) disable iff (!aresetn)
        run && $past(run) && bs_state != $past(bs_state) |-> $past(smp_tick))
        else $error("stream moved off sample point");
    a_pin_timing: assert property (@(posedge aclk) disable iff (!aresetn)
        run && $past(run) && $changed(bus_transmit_pin) |-> $past(tq_tick))
        else $error("pin moved off quantum");
    a_seg1_cap: assert property (@(posedge aclk) disable iff (!aresetn)
        bt_state == BT_SEG1 && run |-> seg1_lim <= seg.seg1_nom + jump5)
        else $error("buffer one over cap");
    a_seg2_cap: assert property (@(posedge aclk) disable iff (!aresetn)
        bt_state == BT_SEG2 && run |-> seg2_lim <= seg.seg2_nom && qcnt < seg2_lim)
        else $error("buffer two out of range");
    a_one_sync: assert property (@(posedge aclk) disable iff (!aresetn)
        edge_seen && !smp_tick |=> !edge_seen until_with smp_tick)
        else $error("second sync in one bit");
endmodule

/* design/cbt_pkg.sv */
// Purpose: Shared constants and types for the CAN bit timing core
// Assumes: AXI4-Lite register access, 32-bit data, byte addresses
// Notes:   Registers are 16 bits wide in the low half of each word
package cbt_pkg;
    localparam logic [7:0]  CTRL_OFS   = 8'h00;
    localparam logic [7:0]  STAT_OFS   = 8'h04;
    localparam logic [7:0]  BTIME_OFS  = 8'h0C;
    localparam logic [7:0]  TXD_OFS    = 8'h10;
    localparam logic [7:0]  RXD_OFS    = 8'h14;
    localparam int          HOLD_POS   = 0;
    localparam int          TXREQ_POS  = 1;
    localparam int          BOFF_POS   = 7;
    localparam int          RXF_POS    = 8;
    localparam int          TXF_POS    = 9;
    localparam int          ERRF_POS   = 10;
    localparam logic [15:0] CTRL_RST   = 16'h0001;
    localparam logic [15:0] BTIME_RST  = 16'h2301;
    localparam logic [4:0]  SEG_ADD    = 5'h03;
    localparam logic [2:0]  STUFF_LEN  = 3'h5;
    localparam logic [4:0]  DATA_LAST  = 5'h08;
    localparam logic [4:0]  CRC_LAST   = 5'h17;
    localparam logic [4:0]  FLAG_BITS  = 5'h06;
    localparam logic [4:0]  IDLE_BITS  = 5'h0B;
    localparam logic [14:0] CRC_POLY   = 15'h4599;
    localparam logic [8:0]  ERR_STEP   = 9'h008;
    localparam logic [1:0]  RESP_OKAY  = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic       unused;
        logic [2:0] after_sample_field;
        logic [3:0] before_sample_field;
        logic [1:0] resync_jump_limit;
        logic [5:0] quantum_prescaler;
    } cbt_btime_t;

    typedef struct packed {
        logic [4:0] seg1_nom;
        logic [4:0] seg2_nom;
        logic [2:0] jump;
    } cbt_seg_t;

    typedef enum logic [1:0] {BT_SYNC, BT_SEG1, BT_SEG2} cbt_bt_state_t;
    typedef enum logic [1:0] {BS_WAIT, BS_IDLE, BS_FRAME, BS_FLAG} cbt_bs_state_t;
endpackage

/* dv/cbt_bus_node.sv */
// Purpose: Far-side CAN node seen through a transceiver on a wired-AND bus
// Assumes: Recessive is high; the bus idles recessive when no node drives
// Notes:   Drives dominant only when the bench commands it
`timescale 1ns/1ps
module cbt_bus_node (
    // Pins of the block under test
    input  wire logic tx_pin,
    output logic      rx_pin,
    // Bench command
    input  wire logic pull_dominant
);
    // Loop delay keeps receive edges off the clock edge
    assign #2 rx_pin = tx_pin & ~pull_dominant;
endmodule

/* dv/tb.sv */
// Purpose: Self-checking bench for the CAN bit timing core
// Assumes: 125 MHz clock, bus looped back through one far-side node
// Notes:   Handshakes are sampled at the falling edge, acted on at the rising one
`timescale 1ns/1ps
module tb;
    import cbt_pkg::*;
    logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, rx, tx, pull_dom;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, rs;
    int          err_count, total_checks, cyc, n;
    logic [15:0] row_w [4] = '{16'h1600, 16'h34C1, 16'hFFFF, 16'h0100};
    logic [4:0]  row_len [4] = '{5'h0A, 5'h0A, 5'h19, 5'h04};
    always #4 aclk = ~aclk;
    cbt_core dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
        .rdata(rdata), .rresp(rresp), .bus_receive_pin(rx), .bus_transmit_pin(tx));
    cbt_bus_node node (.tx_pin(tx), .rx_pin(rx), .pull_dominant(pull_dom));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ta, tw;
        ta = 0;
        tw = 0;
        @(posedge aclk);
        awaddr <= a; wdata <= d; wstrb <= 4'hF; awvalid <= 1; wvalid <= 1; bready <= 1;
        while (!(ta && tw)) begin
            @(negedge aclk);
            if (awvalid && awready) ta = 1;
            if (wvalid && wready) tw = 1;
            @(posedge aclk);
            if (ta) awvalid <= 0;
            if (tw) wvalid <= 0;
        end
        ta = 0;
        while (!ta) begin
            @(negedge aclk);
            ta = bvalid;
            r = bresp;
            @(posedge aclk);
        end
        bready <= 0;
    endtask
    task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic t;
        t = 0;
        @(posedge aclk);
        araddr <= a; arvalid <= 1; rready <= 1;
        while (!t) begin
            @(negedge aclk);
            t = arready;
            @(posedge aclk);
            if (t) arvalid <= 0;
        end
        t = 0;
        while (!t) begin
            @(negedge aclk);
            t = rvalid; d = rdata; r = rresp;
            @(posedge aclk);
        end
        rready <= 0;
    endtask
    // Ceiling well above one short frame, the start of a second and register traffic
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            conclude();
        end
    end
    initial begin
        {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, pull_dom} = '0;
        {awaddr, araddr, wdata, wstrb, cyc, err_count, total_checks} = '0;
        repeat (8) @(posedge aclk);
        aresetn <= 1;
        pull_dom <= 1;
        rdr(CTRL_OFS, rd, rs); chk(rd, 32'h1);
        chk({31'h0, tx}, 32'h1);
        pull_dom <= 0;
        rdr(STAT_OFS, rd, rs); chk(rd[10:0], 11'h008);
        rdr(BTIME_OFS, rd, rs); chk(rd, 32'h2301);
        for (int i = 0; i < 4; i++) begin
            wr(BTIME_OFS, {16'h0, row_w[i]}, rs);
            rdr(BTIME_OFS, rd, rs); chk(rd, {17'h0, row_w[i][14:0]});
            rdr(STAT_OFS, rd, rs); chk(rd[4:0], row_len[i]);
        end
        rdr(8'h08, rd, rs); chk({30'h0, rs}, {30'h0, RESP_SLVERR});
        chk(rd, 32'h0);
        wr(8'h1C, 32'h5, rs); chk(rs, RESP_SLVERR);
        // Two-cycle quanta, ten per bit: three quanta of propagation cover the
        // four-cycle loop through the pin synchroniser; buffer one of six quanta, two of three, jump of three
        wr(BTIME_OFS, 32'h2581, rs);
        wr(TXD_OFS, 32'hAA, rs);
        wr(CTRL_OFS, 32'h2, rs);
        wr(BTIME_OFS, 32'h7FFF, rs);
        rdr(BTIME_OFS, rd, rs); chk(rd, 32'h2581);
        // Twelve recessive bits of twenty cycles pass before the start bit
        n = 0;
        while (tx) begin @(negedge aclk); n++; end
        chk(n >= 200 && n <= 260, 1);
        // Own start edge is seen three quanta late; the hard sync adds them
        n = 0;
        while (!tx) begin @(negedge aclk); n++; end
        chk(n, 26);
        n = 0;
        while (tx) begin @(negedge aclk); n++; end
        chk(n, 20);
        // Late own edge lengthens buffer one by three quanta, the jump limit
        n = 0;
        while (!tx) begin @(negedge aclk); n++; end
        chk(n, 26);
        n = 0;
        rd = '0;
        while (!rd[TXF_POS] && n < 1000) begin rdr(STAT_OFS, rd, rs); n++; end
        chk(rd[TXF_POS], 1);
        wr(CTRL_OFS, 32'h2, rs);
        while (tx) @(negedge aclk);
        @(posedge aclk) aresetn <= 0;
        repeat (4) @(posedge aclk);
        aresetn <= 1;
        @(negedge aclk) chk({31'h0, tx}, 32'h1);
        rdr(CTRL_OFS, rd, rs); chk(rd, 32'h1);
        rdr(TXD_OFS, rd, rs); chk(rd, 32'hAA);
        rdr(STAT_OFS, rd, rs); chk(rd[BOFF_POS], 0);
        conclude();
    end
endmodule
